// >>> hw/osdcf_pkg.sv
// Package with shared constants and types for the character-display command framing block.
package osdcf_pkg;
    // Special character codes held in both banks.
    localparam logic [7:0] OSDCF_CODE_TRANSPARENT = 8'hfe;
    localparam logic [7:0] OSDCF_CODE_END = 8'hff;
    // Glyph store geometry.
    localparam int OSDCF_GLYPH_COUNT = 512;
    localparam int OSDCF_CELL_W = 12;
    localparam int OSDCF_CELL_H = 18;
    // Reset values.
    localparam logic [7:0] OSDCF_RST_BYTE = 8'h00;
    localparam logic [2:0] OSDCF_RST_BITCNT = 3'h0;

    // Framing states of the serial command parser.
    typedef enum logic [1:0] {
        OSDCF_ST_FIRST = 2'b00,
        OSDCF_ST_SECOND = 2'b01,
        OSDCF_ST_SUCC = 2'b10
    } osdcf_state_t;

    // Background modes as selected by the display control logic.
    typedef enum logic [1:0] {
        OSDCF_BG_NONE = 2'b00,
        OSDCF_BG_MIN = 2'b01,
        OSDCF_BG_ALL = 2'b10
    } osdcf_bg_t;

    // Meaning of a decoded character code.
    typedef enum logic [1:0] {
        OSDCF_CK_GLYPH = 2'b00,
        OSDCF_CK_EMPTY = 2'b01,
        OSDCF_CK_TRANSPARENT = 2'b10,
        OSDCF_CK_END = 2'b11
    } osdcf_kind_t;

    // One framed byte handed from the link side to the core side.
    typedef struct packed {
        logic first;
        logic [7:0] data;
    } osdcf_byte_t;
endpackage : osdcf_pkg

// >>> hw/osdcf_top.sv
// Serial command framing and character code decode for the character display.
`timescale 1ns/1ps
module osdcf_top
    import osdcf_pkg::*;
#(
    parameter int CELL_W = OSDCF_CELL_W,
    parameter int CELL_H = OSDCF_CELL_H
) (
    input wire logic clk,
    input wire logic rstn,
    input wire logic ser_clk,
    input wire logic ser_data,
    input wire logic cs_n,
    input wire logic msb_first,
    input wire logic cmd_two_byte,
    input wire logic cmd_successive,
    input wire logic [1:0] bg_mode,
    input wire logic glyph_we,
    input wire logic [8:0] glyph_waddr,
    input wire logic [CELL_W*CELL_H-1:0] glyph_wdata,
    input wire logic [8:0] look_code,
    output logic cmd_valid,
    output logic [15:0] cmd_word,
    output logic cmd_two,
    output logic char_valid,
    output logic [8:0] char_code,
    output logic succ_active,
    output logic [1:0] look_kind,
    output logic look_video,
    output logic look_background,
    output logic [CELL_W*CELL_H-1:0] look_pattern
);
    // Link domain: bytes shift in on ser_clk rising edges while chip select is low.
    // Chip select is asynchronous reset for the shifter, so a released frame restarts byte alignment.
    logic [7:0] shift;
    logic [2:0] bitcnt;
    logic [7:0] link_byte;
    logic link_tog;
    logic link_first;
    logic frame_open;

    wire link_rst_n = rstn & ~cs_n;
    wire [7:0] next_shift = msb_first ? {shift[6:0], ser_data} : {ser_data, shift[7:1]};

    // Shift register and byte capture; the toggle carries each byte across.
    always_ff @(posedge ser_clk or negedge link_rst_n) begin
        if (!link_rst_n) begin
            shift <= OSDCF_RST_BYTE;
            bitcnt <= OSDCF_RST_BITCNT;
            frame_open <= 1'b0;
        end else begin
            shift <= next_shift;
            bitcnt <= bitcnt + 3'h1;
            if (bitcnt == 3'h7) begin
                frame_open <= 1'b1;
            end
        end
    end

    // Byte holding register; held after chip select rises so the core can read it safely.
    always_ff @(posedge ser_clk or negedge rstn) begin
        if (!rstn) begin
            link_byte <= OSDCF_RST_BYTE;
            link_tog <= 1'b0;
            link_first <= 1'b0;
        end else if (!cs_n && bitcnt == 3'h7) begin
            link_byte <= next_shift;
            link_tog <= ~link_tog;
            link_first <= ~frame_open;
        end
    end

    // Core domain: three-stage synchronisers on the toggle and on chip select.
    logic [2:0] tog_sync;
    logic [2:0] cs_sync;
    logic cs_high;
    osdcf_byte_t rx;

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            tog_sync <= 3'h0;
            cs_sync <= 3'h7;
        end else begin
            tog_sync <= {tog_sync[1:0], link_tog};
            cs_sync <= {cs_sync[1:0], cs_n};
        end
    end

    // A change counts once the second and third stages agree on it.
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            cs_high <= 1'b1;
        end else if (cs_sync[1] == cs_sync[2]) begin
            cs_high <= cs_sync[2];
        end
    end

    // Remembers the last toggle level taken, so each byte is seen exactly once.
    logic tog_seen;
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            tog_seen <= 1'b0;
        end else if (tog_sync[1] == tog_sync[2]) begin
            tog_seen <= tog_sync[2];
        end
    end

    // A byte counts only once the second and third stages agree on a new level.
    wire byte_evt = (tog_sync[1] == tog_sync[2]) && (tog_sync[2] != tog_seen);
    assign rx.first = link_first;
    assign rx.data = link_byte;

    // Command framing state machine.
    osdcf_state_t state;
    logic [7:0] first_byte;
    logic bank;

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            state <= OSDCF_ST_FIRST;
            first_byte <= OSDCF_RST_BYTE;
            bank <= 1'b0;
            cmd_valid <= 1'b0;
            cmd_word <= 16'h0000;
            cmd_two <= 1'b0;
            char_valid <= 1'b0;
            char_code <= 9'h000;
        end else begin
            cmd_valid <= 1'b0;
            char_valid <= 1'b0;
            if (cs_high) begin
                state <= OSDCF_ST_FIRST;
            end else if (byte_evt) begin
                // The first byte of a frame always starts a command, even if a short release escaped the synchroniser.
                case (rx.first ? OSDCF_ST_FIRST : state)
                    OSDCF_ST_FIRST: begin
                        if (cmd_two_byte || cmd_successive) begin
                            first_byte <= rx.data;
                            state <= OSDCF_ST_SECOND;
                        end else begin
                            cmd_valid <= 1'b1;
                            cmd_word <= {8'h00, rx.data};
                            cmd_two <= 1'b0;
                        end
                    end
                    OSDCF_ST_SECOND: begin
                        // The second byte must come in the same chip-select frame.
                        cmd_valid <= 1'b1;
                        cmd_word <= {first_byte, rx.data};
                        cmd_two <= 1'b1;
                        bank <= first_byte[0];
                        state <= cmd_successive ? OSDCF_ST_SUCC : OSDCF_ST_FIRST;
                    end
                    OSDCF_ST_SUCC: begin
                        if (rx.data == OSDCF_CODE_END) begin
                            // End code closes the sequence; next byte is a new command.
                            state <= OSDCF_ST_FIRST;
                        end else begin
                            // Abbreviated character writes stay in the selected bank.
                            char_valid <= 1'b1;
                            char_code <= {bank, rx.data};
                        end
                    end
                    default: begin
                        state <= OSDCF_ST_FIRST;
                    end
                endcase
            end
        end
    end

    // Chip select release also ends successive mode; output mirrors the state.
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            succ_active <= 1'b0;
        end else begin
            succ_active <= (state == OSDCF_ST_SUCC) && !cs_high;
        end
    end

    // Glyph store of 512 patterns, 12x18 dots each.
    logic [CELL_W*CELL_H-1:0] glyph_mem [OSDCF_GLYPH_COUNT];

    // Writes to the fixed codes are dropped in both banks.
    always_ff @(posedge clk) begin
        if (glyph_we && glyph_waddr[7:1] != 7'h7f) begin
            glyph_mem[glyph_waddr] <= glyph_wdata;
        end
    end

    // Classify a code; the fixed codes win over whatever the store holds.
    function automatic osdcf_kind_t osdcf_classify(input logic [7:0] code, input logic blank);
        if (code == OSDCF_CODE_END) begin
            osdcf_classify = OSDCF_CK_END;
        end else if (code == OSDCF_CODE_TRANSPARENT) begin
            osdcf_classify = OSDCF_CK_TRANSPARENT;
        end else if (blank) begin
            osdcf_classify = OSDCF_CK_EMPTY;
        end else begin
            osdcf_classify = OSDCF_CK_GLYPH;
        end
    endfunction : osdcf_classify

    // Registered lookup; one cycle from look_code to the result.
    logic [CELL_W*CELL_H-1:0] rd_pat;
    osdcf_kind_t next_kind;
    always_comb begin
        rd_pat = glyph_mem[look_code];
        next_kind = osdcf_classify(look_code[7:0], rd_pat == '0);
    end

    // Cell display decision per background mode.
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            look_kind <= OSDCF_CK_GLYPH;
            look_video <= 1'b0;
            look_background <= 1'b0;
            look_pattern <= '0;
        end else begin
            look_kind <= next_kind;
            look_pattern <= (next_kind == OSDCF_CK_GLYPH) ? rd_pat : '0;
            case (next_kind)
                OSDCF_CK_EMPTY: begin
                    look_video <= (bg_mode == OSDCF_BG_NONE);
                    look_background <= (bg_mode != OSDCF_BG_NONE);
                end
                OSDCF_CK_TRANSPARENT: begin
                    look_video <= 1'b1;
                    look_background <= 1'b0;
                end
                default: begin
                    look_video <= 1'b0;
                    look_background <= (bg_mode != OSDCF_BG_NONE);
                end
            endcase
        end
    end
endmodule : osdcf_top

// >>> tb/osdcf_checker.sv
// Assertions on the framing block ports.
`timescale 1ns/1ps
module osdcf_checker
    import osdcf_pkg::*;
#(parameter int CELL_W = 12, parameter int CELL_H = 18) (
    input wire logic clk,
    input wire logic rstn,
    input wire logic [1:0] bg_mode,
    input wire logic [8:0] look_code,
    input wire logic cmd_valid,
    input wire logic [15:0] cmd_word,
    input wire logic char_valid,
    input wire logic [8:0] char_code,
    input wire logic [1:0] look_kind,
    input wire logic look_background,
    input wire logic [CELL_W*CELL_H-1:0] look_pattern
);
    default clocking @(posedge clk);
    endclocking
    default disable iff (!rstn);
    // Reserved codes keep their meaning in both banks.
    property p_fe; look_code[7:0] == OSDCF_CODE_TRANSPARENT |=> look_kind == OSDCF_CK_TRANSPARENT; endproperty
    a_fe: assert property (p_fe) else $error("code fe not transparent");
    property p_ff; look_code[7:0] == OSDCF_CODE_END |=> look_kind == OSDCF_CK_END; endproperty
    a_ff: assert property (p_ff) else $error("code ff not end");
    property p_tbg; look_kind == OSDCF_CK_TRANSPARENT |-> !look_background; endproperty
    a_tbg: assert property (p_tbg) else $error("background in transparent cell");
    property p_ebg; look_kind == OSDCF_CK_EMPTY |-> look_background == ($past(bg_mode) != OSDCF_BG_NONE); endproperty
    a_ebg: assert property (p_ebg) else $error("empty cell background wrong");
    property p_pat; look_kind != OSDCF_CK_GLYPH |-> look_pattern == '0; endproperty
    a_pat: assert property (p_pat) else $error("pattern on special code");
    // The end code never becomes a character.
    property p_noend; char_valid |-> char_code[7:0] != OSDCF_CODE_END; endproperty
    a_noend: assert property (p_noend) else $error("end code written as char");
    property p_pulse; cmd_valid |=> !cmd_valid; endproperty
    a_pulse: assert property (p_pulse) else $error("command pulse too long");
    property p_hold; !$stable(char_code) |-> char_valid; endproperty
    a_hold: assert property (p_hold) else $error("char code moved without pulse");
    c_cmd: cover property (cmd_valid);
    c_char: cover property (char_valid);
    c_empty: cover property (look_kind == OSDCF_CK_EMPTY && look_background);
endmodule : osdcf_checker
bind osdcf_top osdcf_checker #(.CELL_W(CELL_W), .CELL_H(CELL_H)) i_chk (.clk, .rstn, .bg_mode, .look_code,
    .cmd_valid, .cmd_word, .char_valid, .char_code, .look_kind, .look_background, .look_pattern);

// >>> tb/osdcf_host.sv
// Host model driving the serial command link.
`timescale 1ns/1ps
module osdcf_host (
    output logic ser_clk,
    output logic ser_data,
    output logic cs_n,
    input wire logic msb_first
);
    initial begin
        ser_clk = 1'b0;
        ser_data = 1'b1;
        cs_n = 1'b1;
    end
    // Chip select stays low across bytes; the clock runs only inside a frame.
    task automatic send(input logic [7:0] b);
        if (cs_n) begin
            cs_n = 1'b0;
            #300;
        end
        for (int i = 0; i < 8; i++) begin
            ser_data = msb_first ? b[7-i] : b[i];
            #6 ser_clk = 1'b1;
            #6 ser_clk = 1'b0;
        end
        ser_data = ~ser_data; // Stale bit is not left on the line.
    endtask : send
    // Closes the frame after the hold time the last command needs.
    task automatic finish_frame(input logic succ);
        #(succ ? 3000 : 400) cs_n = 1'b1;
    endtask : finish_frame
endmodule : osdcf_host

// >>> tb/tb_osdcf_top.sv
// Self-checking bench for the framing block.
`timescale 1ns/1ps
module tb_osdcf_top;
    import osdcf_pkg::*;
    logic clk = 1'b0, rstn = 1'b0, ser_clk, ser_data, cs_n, cmd_two_byte = 1'b0, cmd_successive = 1'b0;
    logic glyph_we = 1'b0, cmd_valid, cmd_two, char_valid, succ_active, look_video, look_background;
    logic msb_first = 1'b1;
    logic [1:0] bg_mode = 2'h0, look_kind;
    logic [8:0] glyph_waddr = 9'h000, look_code = 9'h000, char_code;
    logic [215:0] glyph_wdata = 216'h0, look_pattern;
    logic [15:0] cmd_word;
    int miscompares = 0, n_compared = 0;
    always #5 clk = ~clk;
    osdcf_host i_host (.ser_clk, .ser_data, .cs_n, .msb_first);
    osdcf_top i_dut (.clk, .rstn, .ser_clk, .ser_data, .cs_n, .msb_first, .cmd_two_byte, .cmd_successive,
        .bg_mode, .glyph_we, .glyph_waddr, .glyph_wdata, .look_code, .cmd_valid, .cmd_word, .cmd_two, .char_valid,
        .char_code, .succ_active, .look_kind, .look_video, .look_background, .look_pattern);
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_compared++;
        if (got !== exp) begin
            miscompares++;
            $display("BAD at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic test_done();
        $display("compared %0d mismatches %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : test_done
    // Bounded wait for a pulse; a missing pulse ends the run when one is wanted.
    task automatic pulse(input logic is_char, input logic want);
        logic hit;
        hit = 1'b0;
        for (int i = 0; i < 30 && !hit; i++) begin
            @(posedge clk);
            #1 hit = ((is_char ? char_valid : cmd_valid) === 1'b1);
        end
        chk({15'h0, hit}, {15'h0, want});
        if (want && !hit) test_done();
    endtask : pulse
    task automatic mode(input logic [1:0] m);
        @(posedge clk) {cmd_two_byte, cmd_successive} <= m;
    endtask : mode
    // Opens a successive run and writes one abbreviated char.
    task automatic run(input logic [7:0] hdr, input logic [7:0] c);
        mode(2'b01);
        i_host.send(hdr);
        i_host.send(8'h20);
        repeat (30) @(posedge clk);
        i_host.send(c);
        pulse(1'b1, 1'b1);
        chk({7'h0, char_code}, {7'h0, hdr[0], c});
        chk({15'h0, succ_active}, 16'h1);
    endtask : run
    task automatic cmd1(input logic [7:0] b);
        mode(2'b00);
        i_host.send(b);
        pulse(1'b0, 1'b1);
        chk(cmd_word, {8'h00, b});
        chk({15'h0, cmd_two}, 16'h0);
    endtask : cmd1
    // Two-byte command in the given bit order; chip select stays low between the bytes.
    task automatic two(input logic lsb, input logic [7:0] b1, input logic [7:0] b2);
        repeat (10) @(posedge clk);
        msb_first <= !lsb;
        mode(2'b10);
        i_host.send(b1);
        i_host.send(b2);
        pulse(1'b0, 1'b1);
        chk(cmd_word, {b1, b2});
        chk({15'h0, cmd_two}, 16'h1);
        i_host.finish_frame(1'b0);
    endtask : two
    task automatic wr(input logic [8:0] a, input logic [215:0] d);
        @(posedge clk);
        glyph_we <= 1'b1;
        glyph_waddr <= a;
        glyph_wdata <= d;
        @(posedge clk) glyph_we <= 1'b0;
    endtask : wr
    task automatic look(input logic [8:0] c, input logic [1:0] k, input logic b);
        @(posedge clk) look_code <= c;
        @(posedge clk);
        #1 chk({14'h0, look_kind}, {14'h0, k});
        if (k inside {OSDCF_CK_EMPTY, OSDCF_CK_TRANSPARENT}) begin
            chk({15'h0, look_background}, {15'h0, b});
            chk({15'h0, look_video}, {15'h0, k == OSDCF_CK_TRANSPARENT || !b});
        end
    endtask : look
    initial begin
        repeat (3) @(posedge clk);
        rstn <= 1'b1;
        repeat (4) @(posedge clk);
        // End code closes the run while chip select stays low.
        cmd1(8'ha5);
        run(8'h41, 8'h30);
        i_host.send(OSDCF_CODE_END);
        pulse(1'b1, 1'b0);
        chk({15'h0, succ_active}, 16'h0);
        cmd1(8'h5a);
        i_host.finish_frame(1'b0);
        $display("end code test done");
        // Raising chip select also closes the run.
        run(8'h40, 8'h31);
        i_host.finish_frame(1'b1);
        repeat (10) @(posedge clk);
        chk({15'h0, succ_active}, 16'h0);
        cmd1(8'h3c);
        i_host.finish_frame(1'b0);
        $display("chip select test done");
        // Two-byte commands in both bit orders.
        two(1'b0, 8'h81, 8'h3c);
        two(1'b1, 8'h12, 8'hc4);
        $display("two-byte test done");
        // Reserved codes refuse glyphs; blank glyphs read as empty cells.
        for (int a = 0; a < 2; a++) begin
            wr({a[0], 8'h05}, {18{12'h801}});
            wr({a[0], 8'h06}, 216'h0);
            wr({a[0], 8'hfe}, {18{12'h801}});
        end
        for (int m = 0; m < 3; m++) begin
            @(posedge clk) bg_mode <= m[1:0];
            look(9'h006, OSDCF_CK_EMPTY, m != 0);
            look(9'h106, OSDCF_CK_EMPTY, m != 0);
            look(9'h0fe, OSDCF_CK_TRANSPARENT, 1'b0);
            look(9'h1fe, OSDCF_CK_TRANSPARENT, 1'b0);
            look(9'h0ff, OSDCF_CK_END, 1'b0);
            look(9'h1ff, OSDCF_CK_END, 1'b0);
        end
        look(9'h105, OSDCF_CK_GLYPH, 1'b0);
        chk(look_pattern[15:0], 16'h1801);
        $display("code test done");
        test_done();
    end
endmodule : tb_osdcf_top
